// File: spc_defs.vh
// register map, field positions and reset values of the power-mode controller
`ifndef SPC_DEFS_VH
`define SPC_DEFS_VH
// =====================================================
// register byte offsets
`define SPC_OFF_CLKCTRL   4'h0
`define SPC_OFF_MODESEL   4'h4
`define SPC_OFF_PROTECT   4'h8
`define SPC_OFF_PWRSAVE   4'hC
// =====================================================
// clock control fields
`define SPC_CK_DIV_LO     0
`define SPC_CK_DIV_HI     2
`define SPC_CK_SUBSEL     3
`define SPC_CK_OSCSTOP    6
`define SPC_CK_STATUS     4
// =====================================================
// other fields and values
`define SPC_PSM_BIT       0
`define SPC_STP_BIT       1
`define SPC_PROT_KEY      8'hA5
`define SPC_RST_BYTE      8'h00
`define SPC_RESP_OKAY     2'h0
`define SPC_RESP_SLVERR   2'h2
`endif

// File: spc_sync.v
// two-flop synchroniser for a bundle of asynchronous inputs
module spc_sync #(
   parameter W = 1
)(
   // clock and reset
   input  wire         sys_clk,
   input  wire         rst,
   // data
   input  wire [W-1:0] asyncIn,
   output wire [W-1:0] syncOut
);
   reg [W-1:0] stage1_q;
   reg [W-1:0] stage2_q;

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1)
      begin : gBit
         always @(posedge sys_clk or posedge rst)
         begin
            if (rst)
            begin
               stage1_q[i] <= 1'b0;
               stage2_q[i] <= 1'b0;
            end
            else
            begin
               stage1_q[i] <= asyncIn[i];
               stage2_q[i] <= stage1_q[i];
            end
         end
      end
   endgenerate

   assign syncOut = stage2_q;
endmodule

// File: spc_wake.v
// wake-up request decode for sub-idle release
module spc_wake #(
   parameter NEXT = 7,
   parameter NINT = 8,
   parameter PW   = 3
)(
   // requests
   input  wire            nmiReq,
   input  wire [NEXT-1:0] extReq,
   input  wire [NEXT-1:0] extMask,
   input  wire [NINT-1:0] intReq,
   input  wire [NINT-1:0] intMask,
   input  wire [NINT-1:0] intSubOk,
   // priority of requests and of the running handler (0 is highest)
   input  wire [PW-1:0]   reqPrio,
   input  wire [PW-1:0]   curPrio,
   input  wire            inHandler,
   // results
   output wire            wakeAny,
   output wire            ackOk
);
   wire maskable;
   // internal sources wake only if still clocked in sub-idle; external and nmi always may
   assign maskable = (|(extReq & ~extMask)) | (|(intReq & ~intMask & intSubOk));
   assign wakeAny  = nmiReq | maskable;
   // lower-priority requests only wake, higher ones are acknowledged too
   assign ackOk    = nmiReq | (maskable & (~inHandler | (reqPrio < curPrio)));
endmodule

// File: spc_power_ctrl.v
// subclock and sub-idle power control with axi4-lite registers
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`include "spc_defs.vh"

// Behaviour
// - writing subclock select in normal mode switches system clock to subclock
// - writing oscillator stop bit halts main oscillator, subclock only; the code also honours the bit in normal mode
// - watchdog frozen, holding its count, once clock status shows subclock
// - subclock mode ends on reset or clearing select; restart oscillator first
// - leaving subclock mode returns main clock as system clock
// - main stopped: serial only on external clock; bus, uarts, adc halted
// - main stopped: dac normal mode only; rtc only on subclock count clock
// - sub-idle entered in subclock mode when mode bit 0 and stop set
// - sub-idle keeps oscillator, gates cpu and peripheral clocks
// - sub-idle keeps subclock or externally clocked peripherals running
// - sub-idle ends on nmi, unmasked external or internal request, reset
// - interrupt wake resumes subclock mode; reset returns normal mode
// - any unmasked or non-maskable request wakes, whatever its priority
// - in handler, lower-priority request only wakes and stays pending
// - in handler, higher-priority or nmi request wakes and is acknowledged
// - nmi branches; maskable branches if enabled, else next instruction
// - power-save register written only after protect key write
module spc_power_ctrl #(
   parameter NEXT = 7,
   parameter NINT = 8,
   parameter PW   = 3
)(
   // clock and reset
   input  wire            sys_clk,
   input  wire            rst,
   // axi4-lite write address
   input  wire [3:0]      s_axi_awaddr,
   input  wire            s_axi_awvalid,
   output wire            s_axi_awready,
   // axi4-lite write data
   input  wire [31:0]     s_axi_wdata,
   input  wire [3:0]      s_axi_wstrb,
   input  wire            s_axi_wvalid,
   output wire            s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]      s_axi_bresp,
   output reg             s_axi_bvalid,
   input  wire            s_axi_bready,
   // axi4-lite read
   input  wire [3:0]      s_axi_araddr,
   input  wire            s_axi_arvalid,
   output wire            s_axi_arready,
   output reg  [31:0]     s_axi_rdata,
   output reg  [1:0]      s_axi_rresp,
   output reg             s_axi_rvalid,
   input  wire            s_axi_rready,
   // wake sources (pins are asynchronous)
   input  wire            nmiPin,
   input  wire [NEXT-1:0] extIntPin,
   input  wire [NEXT-1:0] extMask,
   input  wire [NINT-1:0] intReq,
   input  wire [NINT-1:0] intMask,
   input  wire [NINT-1:0] intSubOk,
   input  wire [PW-1:0]   reqPrio,
   input  wire [PW-1:0]   curPrio,
   input  wire            inHandler,
   input  wire            intEnabled,
   // peripheral clock choices
   input  wire            rtcOnSubclk,
   input  wire            dacNormalMode,
   input  wire [4:0]      csiExtClk,
   // clock and gate controls
   output reg             subClkSel,
   output reg             mainOscEn,
   output reg             cpuClkEn,
   output reg             wdtRun,
   output reg             i2cRun,
   output reg             uartRun,
   output reg             adcRun,
   output reg             dacRun,
   output reg             rtcRun,
   output reg  [4:0]      csiRun,
   output reg             timerRun,
   // wake results
   output reg             wakeAck,
   output reg             wakeBranch,
   output reg             subIdle
);
   // =====================================================
   // states
   localparam [2:0] ST_NORMAL = 3'b001;
   localparam [2:0] ST_SUB    = 3'b010;
   localparam [2:0] ST_IDLE   = 3'b100;
   reg  [2:0] state_q;
   reg  [2:0] state_d;
   reg  [2:0] clkDiv_q;
   reg        subSel_q;
   reg        oscStop_q;
   reg        modeSel_q;
   reg        stopReq_q;
   reg        unlocked_q;
   reg        awHeld_q;
   reg        wHeld_q;
   reg  [3:0] awAddr_q;
   reg [31:0] wData_q;
   reg  [3:0] wStrb_q;
   wire            nmiSync;
   wire [NEXT-1:0] extSync;
   wire            wakeAny;
   wire            ackOk;
   wire            clkStatus;
   wire            mainStopped;
   wire            doWrite;
   wire            wrClk;
   wire            wrMode;
   wire            wrProt;
   wire            wrPwr;
   // =====================================================
   // input synchronisers and wake decode
   spc_sync #(.W(NEXT + 1)) uSync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .asyncIn ({nmiPin, extIntPin}),
      .syncOut ({nmiSync, extSync})
   );
   spc_wake #(.NEXT(NEXT), .NINT(NINT), .PW(PW)) uWake (
      .nmiReq    (nmiSync),
      .extReq    (extSync),
      .extMask   (extMask),
      .intReq    (intReq),
      .intMask   (intMask),
      .intSubOk  (intSubOk),
      .reqPrio   (reqPrio),
      .curPrio   (curPrio),
      .inHandler (inHandler),
      .wakeAny   (wakeAny),
      .ackOk     (ackOk)
   );

   // =====================================================
   // axi4-lite write channel
   assign s_axi_awready = ~awHeld_q & ~s_axi_bvalid;
   assign s_axi_wready  = ~wHeld_q & ~s_axi_bvalid;
   assign doWrite       = awHeld_q & wHeld_q & ~s_axi_bvalid;
   assign wrClk  = doWrite & wStrb_q[0] & (awAddr_q == `SPC_OFF_CLKCTRL);
   assign wrMode = doWrite & wStrb_q[0] & (awAddr_q == `SPC_OFF_MODESEL);
   assign wrProt = doWrite & wStrb_q[0] & (awAddr_q == `SPC_OFF_PROTECT);
   assign wrPwr  = doWrite & wStrb_q[0] & (awAddr_q == `SPC_OFF_PWRSAVE);
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         awHeld_q     <= 1'b0;
         wHeld_q      <= 1'b0;
         awAddr_q     <= 4'h0;
         wData_q      <= 32'h0;
         wStrb_q      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `SPC_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid & s_axi_awready)
         begin
            awHeld_q <= 1'b1;
            awAddr_q <= {s_axi_awaddr[3:2], 2'b00};
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (doWrite)
         begin
            awHeld_q     <= 1'b0;
            wHeld_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `SPC_RESP_OKAY;
         end
         else if (s_axi_bvalid & s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // =====================================================
   // axi4-lite read channel
   assign s_axi_arready = ~s_axi_rvalid;
   assign clkStatus     = (state_q != ST_NORMAL);
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= `SPC_RESP_OKAY;
      end
      else if (s_axi_arvalid & s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `SPC_RESP_OKAY;
         s_axi_rdata  <= 32'h0;
         case ({s_axi_araddr[3:2], 2'b00})
            `SPC_OFF_CLKCTRL:
               s_axi_rdata <= {25'h0, oscStop_q, 1'b0, clkStatus, subSel_q, clkDiv_q};
            `SPC_OFF_MODESEL:
               s_axi_rdata <= {31'h0, modeSel_q};
            `SPC_OFF_PROTECT:
               s_axi_rdata <= {31'h0, unlocked_q};
            `SPC_OFF_PWRSAVE:
               s_axi_rdata <= {30'h0, stopReq_q, 1'b0};
            default:
               s_axi_rresp <= `SPC_RESP_SLVERR;
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // =====================================================
   // control registers
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         clkDiv_q   <= 3'h0;
         subSel_q   <= 1'b0;
         oscStop_q  <= 1'b0;
         modeSel_q  <= 1'b0;
         stopReq_q  <= 1'b0;
         unlocked_q <= 1'b0;
         state_q    <= ST_NORMAL;
      end
      else
      begin
         state_q    <= state_d;
         if (wrClk)
         begin
            clkDiv_q  <= wData_q[`SPC_CK_DIV_HI:`SPC_CK_DIV_LO];
            subSel_q  <= wData_q[`SPC_CK_SUBSEL];
            oscStop_q <= wData_q[`SPC_CK_OSCSTOP];
         end
         if (wrMode)
            modeSel_q <= wData_q[`SPC_PSM_BIT];
         if (wrProt)
            unlocked_q <= (wData_q[7:0] == `SPC_PROT_KEY);
         else if (doWrite)
            unlocked_q <= 1'b0;
         // stop request latch, wake clears it
         if (state_q == ST_IDLE && wakeAny)
            stopReq_q <= 1'b0;
         else if (wrPwr && unlocked_q)
            stopReq_q <= wData_q[`SPC_STP_BIT];
      end
   end

   // =====================================================
   // mode state machine
   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_NORMAL:
            if (subSel_q)
               state_d = ST_SUB;
         ST_SUB:
            if (!subSel_q)
               state_d = ST_NORMAL;
            else if (!modeSel_q && stopReq_q)
               state_d = ST_IDLE;
         ST_IDLE:
            if (wakeAny)
               state_d = ST_SUB;
         default:
            state_d = ST_NORMAL;
      endcase
   end

   // =====================================================
   // clock and peripheral gating, wake results
   assign mainStopped = oscStop_q;
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         subClkSel <= 1'b0;
         mainOscEn <= 1'b1;
         cpuClkEn  <= 1'b1;
         wdtRun    <= 1'b1;
         i2cRun    <= 1'b1;
         uartRun   <= 1'b1;
         adcRun    <= 1'b1;
         dacRun    <= 1'b1;
         rtcRun    <= 1'b1;
         csiRun    <= 5'h1F;
         timerRun  <= 1'b1;
         subIdle   <= 1'b0;
         wakeAck    <= 1'b0;
         wakeBranch <= 1'b0;
      end
      else
      begin
         subClkSel <= (state_d != ST_NORMAL);
         mainOscEn <= ~mainStopped;
         cpuClkEn  <= (state_d != ST_IDLE);
         subIdle   <= (state_d == ST_IDLE);
         wdtRun    <= (state_d == ST_NORMAL);
         i2cRun    <= (state_d == ST_NORMAL) | (state_d == ST_SUB & ~mainStopped);
         uartRun   <= (state_d == ST_NORMAL) | (state_d == ST_SUB & ~mainStopped);
         adcRun    <= (state_d == ST_NORMAL) | (state_d == ST_SUB & ~mainStopped);
         timerRun  <= (state_d != ST_IDLE);
         csiRun    <= ((state_d == ST_IDLE) | (mainStopped & (state_d != ST_NORMAL))) ?
                      csiExtClk : 5'h1F;
         dacRun    <= (state_d != ST_IDLE) &
                      (~mainStopped | (state_d != ST_SUB) | dacNormalMode);
         rtcRun    <= (state_d == ST_NORMAL) | ~mainStopped | rtcOnSubclk;
         wakeAck    <= (state_q == ST_IDLE) & wakeAny & ackOk;
         // branch on nmi, or enabled maskable
         wakeBranch <= (state_q == ST_IDLE) & wakeAny & ackOk & (nmiSync | intEnabled);
      end
   end
endmodule

// File: spc_power_ctrl_sva.sv
// port assertions for the power-mode controller
module spc_power_ctrl_sva (
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       rst,
   // wake inputs and clock choices
   input wire logic       nmiPin,
   input wire logic       rtcOnSubclk,
   input wire logic       dacNormalMode,
   input wire logic [4:0] csiExtClk,
   // gates and wake results
   input wire logic       subClkSel,
   input wire logic       mainOscEn,
   input wire logic       cpuClkEn,
   input wire logic       wdtRun,
   input wire logic       i2cRun,
   input wire logic       uartRun,
   input wire logic       adcRun,
   input wire logic       dacRun,
   input wire logic       rtcRun,
   input wire logic [4:0] csiRun,
   input wire logic       timerRun,
   input wire logic       wakeAck,
   input wire logic       wakeBranch,
   input wire logic       subIdle
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ==========================================================
   // sequences
   sequence seqMainOff;
      subClkSel && !mainOscEn && $stable(csiExtClk);
   endsequence
   sequence seqNmiIdle;
      (subIdle && nmiPin) [*5];
   endsequence
   // ==========================================================
   // properties
   chk_sub_stops_wdt: assert property (subClkSel |-> !wdtRun)
      else $error("watchdog runs on subclock");
   chk_main_stop_halts: assert property (subClkSel && !mainOscEn |-> !(i2cRun || uartRun || adcRun))
      else $error("bus, uart or adc runs with main stopped");
   chk_csi_ext_only: assert property (seqMainOff [*2] |-> csiRun == csiExtClk)
      else $error("serial channel not on external clock");
   chk_dac_rtc_sub: assert property ((subClkSel && !mainOscEn && !subIdle) [*2]
      |-> rtcRun == $past(rtcOnSubclk) && dacRun == $past(dacNormalMode))
      else $error("dac or rtc gate wrong");
   chk_idle_from_sub: assert property ($rose(subIdle) |-> subClkSel && !cpuClkEn)
      else $error("sub-idle outside subclock mode");
   chk_idle_gates_cpu: assert property (subIdle |-> !(cpuClkEn || timerRun || wdtRun || dacRun))
      else $error("clock left running in sub-idle");
   chk_nmi_wakes: assert property (not seqNmiIdle)
      else $error("nmi did not end sub-idle");
   chk_ack_resumes: assert property (wakeAck |-> subClkSel && !subIdle ##1 !wakeAck)
      else $error("acknowledge not a pulse in subclock mode");
   chk_branch_acked: assert property (wakeBranch |-> wakeAck)
      else $error("branch without acknowledge");
endmodule

bind spc_power_ctrl spc_power_ctrl_sva spc_power_ctrl_sva_inst (.sys_clk, .rst, .nmiPin,
   .rtcOnSubclk, .dacNormalMode, .csiExtClk, .subClkSel, .mainOscEn, .cpuClkEn, .wdtRun,
   .i2cRun, .uartRun, .adcRun, .dacRun, .rtcRun, .csiRun, .timerRun, .wakeAck, .wakeBranch,
   .subIdle);

// File: spc_irq_src.sv
// interrupt request sources that wake the controller
module spc_irq_src (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // bench commands
   input  wire logic       fire,
   input  wire logic [1:0] kind,
   input  wire logic [2:0] line,
   input  wire logic [3:0] lag,
   input  wire logic       subIdle,
   // request levels
   output logic            nmiPin,
   output logic [6:0]      extIntPin,
   output logic [7:0]      intReq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] lagCnt_q;
   logic       armed_q;
   logic       up_q;
   // ==========================================================
   // delayed raise, held until the wake is seen
   // nmi, external, internal
   always @(posedge sys_clk or posedge rst)
      if (rst)
         {armed_q, up_q, lagCnt_q, nmiPin, extIntPin, intReq} <= '0;
      else if (fire)
      begin
         armed_q <= 1'b1;
         lagCnt_q <= lag;
      end
      else if (armed_q && lagCnt_q != 4'h0)
         lagCnt_q <= lagCnt_q - 4'h1;
      else if (armed_q)
      begin
         armed_q <= 1'b0;
         up_q <= 1'b1;
         nmiPin <= (kind == 2'h0);
         extIntPin <= (kind == 2'h1) ? 7'h01 << line : 7'h00;
         intReq <= (kind == 2'h2) ? 8'h01 << line : 8'h00;
      end
      else if (up_q && !subIdle)
      begin
         up_q <= 1'b0;
         {nmiPin, extIntPin, intReq} <= '0;
      end
endmodule

// File: subclock_and_sub_idle_power_control_tb_top.sv
// self-checking bench for the subclock and sub-idle controller
`include "spc_defs.vh"
module subclock_and_sub_idle_power_control_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int STAB = 16;
   logic        sys_clk = 1'b0, rst = 1'b1, fire = 1'b0, sawAck = 1'b0, sawBranch = 1'b0;
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF, lag = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, nmiPin, subIdle;
   logic [1:0]  s_axi_bresp, s_axi_rresp, kind = 2'h0;
   logic        inHandler = 1'b0, intEnabled = 1'b0, rtcOnSubclk = 1'b0, dacNormalMode = 1'b0;
   logic [6:0]  extIntPin, extMask = 7'h0;
   logic [7:0]  intReq, intMask = 8'h0, intSubOk = 8'hFF;
   logic [2:0]  reqPrio = 3'h0, curPrio = 3'h0, line = 3'h0, div;
   logic [4:0]  csiExtClk = 5'h0, csiRun;
   logic        subClkSel, mainOscEn, cpuClkEn, wdtRun, i2cRun, uartRun, adcRun;
   logic        dacRun, rtcRun, timerRun, wakeAck, wakeBranch;
   int          numErrors = 0, checkCount = 0, seed = 55;
   // wake cases: kind, in handler, request prio, current prio, enabled
   logic [9:0]  cases [5] = '{10'h0D4, 10'h137, 10'h2E3, 10'h286, 10'h124};
   wire logic [31:0] gates = {14'h0, subClkSel, mainOscEn, cpuClkEn, wdtRun, i2cRun,
      uartRun, adcRun, dacRun, rtcRun, csiRun, timerRun, wakeAck, wakeBranch, subIdle};

   spc_power_ctrl spc_power_ctrl_inst (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nmiPin, .extIntPin, .extMask,
      .intReq, .intMask, .intSubOk, .reqPrio, .curPrio, .inHandler, .intEnabled, .rtcOnSubclk,
      .dacNormalMode, .csiExtClk, .subClkSel, .mainOscEn, .cpuClkEn, .wdtRun, .i2cRun,
      .uartRun, .adcRun, .dacRun, .rtcRun, .csiRun, .timerRun, .wakeAck, .wakeBranch, .subIdle);
   spc_irq_src spc_irq_src_inst (.sys_clk, .rst, .fire, .kind, .line, .lag, .subIdle,
      .nmiPin, .extIntPin, .intReq);

   always #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      if (fire)
      begin
         sawAck <= 1'b0;
         sawBranch <= 1'b0;
      end
      else
      begin
         if (wakeAck === 1'b1) sawAck <= 1'b1;
         if (wakeBranch === 1'b1) sawBranch <= 1'b1;
      end
   end
   // ==========================================================
   // helpers
   function automatic logic expAck(input logic [9:0] c);
      return c[9:8] == 2'h0 || !c[7] || c[6:4] < c[3:1];
   endfunction
   function automatic logic expBranch(input logic [9:0] c);
      return expAck(c) && (c[9:8] == 2'h0 || c[0]);
   endfunction
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checkCount, numErrors);
      if (numErrors == 0 && checkCount > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp)
      begin
         numErrors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic timeout;
      numErrors++;
      $display("unexpected at %0t: wait ran out", $time);
      report_and_stop;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      logic aw, w, b;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      b = 1'b0;
      while (n < 60 && !b)
      begin
         @(posedge sys_clk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bready && s_axi_bvalid;
         if (b) chk(s_axi_bresp, `SPC_RESP_OKAY);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (b) s_axi_bready <= 1'b0;
         n++;
      end
      if (!b) timeout;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      int n;
      logic ar, r;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      r = 1'b0;
      while (n < 60 && !r)
      begin
         @(posedge sys_clk);
         ar = s_axi_arvalid && s_axi_arready;
         r = s_axi_rready && s_axi_rvalid;
         d = s_axi_rdata;
         if (r) chk(s_axi_rresp, `SPC_RESP_OKAY);
         if (ar) s_axi_arvalid <= 1'b0;
         if (r) s_axi_rready <= 1'b0;
         n++;
      end
      if (!r) timeout;
   endtask
   task automatic enterIdle;
      wr(`SPC_OFF_PROTECT, 32'hA5);
      wr(`SPC_OFF_PWRSAVE, 32'h2);
      tick(3);
   endtask
   // ==========================================================
   // main sequence
   initial
   begin
      tick(5);
      rst <= 1'b0;
      chk(gates, 32'h1FFF8);
      rd(`SPC_OFF_CLKCTRL, rv);
      chk(rv, 32'h0);
      $display("reset test done");
      div = 3'($random(seed));
      csiExtClk <= 5'($random(seed));
      rtcOnSubclk <= 1'($random(seed));
      dacNormalMode <= 1'($random(seed));
      wr(`SPC_OFF_CLKCTRL, {29'h0, div} | 32'h8);
      tick(3);
      chk(subClkSel, 1'b1);
      chk(wdtRun, 1'b0);
      rd(`SPC_OFF_CLKCTRL, rv);
      chk(rv, {29'h0, div} | 32'h18);
      wr(`SPC_OFF_CLKCTRL, {29'h0, div} | 32'h48);
      tick(3);
      chk(mainOscEn, 1'b0);
      chk({i2cRun, uartRun, adcRun}, 3'h0);
      chk(csiRun, csiExtClk);
      chk({rtcRun, dacRun}, {rtcOnSubclk, dacNormalMode});
      wr(`SPC_OFF_MODESEL, 32'h0);
      wr(`SPC_OFF_PWRSAVE, 32'h2);
      tick(3);
      chk(subIdle, 1'b0);
      $display("subclock test done");
      for (int i = 0; i < 5; i++)
      begin
         enterIdle;
         chk(subIdle, 1'b1);
         chk({cpuClkEn, timerRun}, 2'h0);
         chk(csiRun, csiExtClk);
         kind <= cases[i][9:8];
         inHandler <= cases[i][7];
         reqPrio <= cases[i][6:4];
         curPrio <= cases[i][3:1];
         intEnabled <= cases[i][0];
         line <= 3'($unsigned($random(seed)) % 7);
         lag <= (i == 4) ? 4'h0 : 4'($random(seed));
         extMask <= (i == 4) ? 7'h7F : 7'h00;
         fire <= 1'b1;
         tick(1);
         fire <= 1'b0;
         if (i == 4)
         begin
            tick(8);
            chk(subIdle, 1'b1);
            extMask <= 7'h00;
         end
         for (int n = 0; subIdle !== 1'b0; n++)
         begin
            if (n > 60) timeout;
            tick(1);
         end
         tick(3);
         chk(subClkSel, 1'b1);
         chk(sawAck, expAck(cases[i]));
         chk(sawBranch, expBranch(cases[i]));
         $display("wake case %0d done", i);
      end
      wr(`SPC_OFF_CLKCTRL, {29'h0, div} | 32'h8);
      tick(STAB);
      chk(mainOscEn, 1'b1);
      wr(`SPC_OFF_CLKCTRL, {29'h0, div});
      tick(3);
      chk({subClkSel, wdtRun}, 2'h1);
      rd(`SPC_OFF_CLKCTRL, rv);
      chk(rv, {29'h0, div});
      $display("leave test done");
      wr(`SPC_OFF_CLKCTRL, {29'h0, div} | 32'h8);
      tick(3);
      enterIdle;
      chk(subIdle, 1'b1);
      rst <= 1'b1;
      tick(2);
      chk(gates, 32'h1FFF8);
      rst <= 1'b0;
      tick(2);
      chk(gates, 32'h1FFF8);
      rd(`SPC_OFF_CLKCTRL, rv);
      chk(rv, 32'h0);
      $display("reset wake test done");
      report_and_stop;
   end
endmodule
